// >>> irpc_pkg.sv
package irpc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_VECTOR = 8'h0C;

	// Control fields
	localparam int CTRL_AREA_SEL  = 0;
	localparam int CTRL_IRQ_EN    = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Command fields (write only, read as zero)
	localparam int CMD_SLEEP    = 0;
	localparam int CMD_STOP     = 1;
	localparam int CMD_IRQ_ACK  = 2;
	localparam int CMD_NMI_DONE = 3;

	// Status fields
	localparam int ST_NMI_LATCH = 0;
	localparam int ST_NMI_PEND  = 1;
	localparam int ST_IRQ_BUSY  = 2;
	localparam int ST_LVL_LO    = 4;
	localparam int ST_LVL_HI    = 7;
	localparam int ST_MODE_LO   = 8;
	localparam int ST_MODE_HI   = 9;
	localparam int ST_HOLD      = 10;
	localparam int ST_IRQ_REQ   = 11;

	// ****************************************************************
	// Entry addresses
	// ****************************************************************
	localparam logic [31:0] RESET_ADDR   = 32'hFFFFFFF0;
	localparam logic [31:0] NMI_ADDR     = 32'hFFFFFFD0;
	localparam logic [31:0] IRQ_BASE_INT = 32'h0FE00000;
	localparam logic [31:0] IRQ_BASE_EXT = 32'h0FFFFE00;
	localparam int          IRQ_LVL_POS  = 4;

	// Level code is active low: level = max minus code
	localparam logic [3:0] LEVEL_MAX = 4'hF;

	// Status pin codes, values arbitrary
	localparam logic [3:0] STAT_HALT_ACK = 4'hA;
	localparam logic [3:0] STAT_RUN      = 4'h5;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_STOP
	} irpc_mode_t;

endpackage : irpc_pkg

// >>> irpc_sync.sv
`timescale 1ns/1ns
module irpc_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// First stage is read only by the second stage
	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : irpc_sync

// >>> irpc_ctrl.sv
`timescale 1ns/1ns
//
// Contract
// - Level equals fifteen minus the active-low four-bit level code.
// - Maskable request and level lines are level inputs sampled every rising edge.
// - A change missing setup is recognised at the next rising edge.
// - Maskable entry is level-indexed, internal or external base by area select.
// - Nonmaskable input is sampled on rising edges; high-to-low detects a request.
// - Detected nonmaskable request stays latched until handling begins.
// - Nonmaskable entry address is fixed at FFFFFFD0H.
// - New nonmaskable request while pending flag set is held pending.
// - Nonmaskable request during latch clearing at handler start is lost.
// - After reset release, fetch starts from FFFFFFF0H.
// - Sleep entry stops internal clock, keeps PLL, accepts hold, keeps memory.
// - Sleep ends on maskable request, nonmaskable request or reset. A maskable request ends it only with CTRL_IRQ_EN set.
// - Hold in sleep floats status; halt code returns on clock edge after hold.
// - Stop entry stops clock and PLL; only nonmaskable or reset ends it.
// - Stop mode refuses every bus hold request.
module irpc_ctrl (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Request pins
	input  wire logic        irq_req,
	input  wire logic [3:0]  irq_level_code_n,
	input  wire logic        nmi_n,
	input  wire logic        hold_req_n,
	// Bus hold and status pins
	output logic             hold_ack_n,
	output logic      [3:0]  st_out,
	output logic             st_oe,
	// Core control
	output logic      [31:0] branch_addr,
	output logic             branch_stb,
	output logic             core_clk_en,
	output logic             pll_run
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic       irq_s;
	logic [3:0] code_s;
	logic       nmi_s;
	logic       hold_s_n;

	irpc_sync #(
		.W       (7),
		.RST_VAL (7'h3F)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({irq_req, irq_level_code_n, nmi_n, hold_req_n}),
		.q       ({irq_s, code_s, nmi_s, hold_s_n})
	);

	// ****************************************************************
	// State
	// ****************************************************************
	irpc_pkg::irpc_mode_t mode_r;
	logic [1:0]  ctrl_r;
	logic        nmi_prev_r;
	logic        nmi_latch_r;
	logic        nmi_pend_r;
	logic        irq_busy_r;
	logic        boot_r;
	logic [3:0]  level_w;
	logic        nmi_fall_w;
	logic        nmi_take_w;
	logic        irq_take_w;
	logic        irq_wake_w;
	logic        wr_w;
	logic        cmd_w;
	logic        hold_grant_w;
	logic [31:0] irq_vec_w;

	assign level_w    = irpc_pkg::LEVEL_MAX - code_s;
	assign nmi_fall_w = nmi_prev_r && !nmi_s;
	assign irq_wake_w = irq_s && ctrl_r[irpc_pkg::CTRL_IRQ_EN];

	// Handling begins only with the core clock running
	assign nmi_take_w = (mode_r == irpc_pkg::MODE_RUN) && !boot_r
		&& nmi_latch_r && !nmi_pend_r;
	assign irq_take_w = (mode_r == irpc_pkg::MODE_RUN) && !boot_r && irq_wake_w
		&& !irq_busy_r && !nmi_take_w && !nmi_latch_r && !nmi_fall_w;

	assign irq_vec_w = (ctrl_r[irpc_pkg::CTRL_AREA_SEL] ? irpc_pkg::IRQ_BASE_INT
		: irpc_pkg::IRQ_BASE_EXT) | (32'(level_w) << irpc_pkg::IRQ_LVL_POS);

	assign wr_w  = psel && penable && pready && pwrite;
	assign cmd_w = wr_w && (paddr == irpc_pkg::OFS_CMD);

	// Stop refuses hold outright
	assign hold_grant_w = !hold_s_n && (mode_r != irpc_pkg::MODE_STOP);

	// ****************************************************************
	// APB slave, one wait state so read data comes from a flop
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			case (paddr)
				irpc_pkg::OFS_CTRL: begin
					prdata[1:0] <= ctrl_r;
				end
				irpc_pkg::OFS_CMD: begin
					prdata <= 32'h00000000;
				end
				irpc_pkg::OFS_STATUS: begin
					prdata[irpc_pkg::ST_NMI_LATCH] <= nmi_latch_r;
					prdata[irpc_pkg::ST_NMI_PEND]  <= nmi_pend_r;
					prdata[irpc_pkg::ST_IRQ_BUSY]  <= irq_busy_r;
					prdata[irpc_pkg::ST_LVL_HI:irpc_pkg::ST_LVL_LO] <= level_w;
					prdata[irpc_pkg::ST_MODE_HI:irpc_pkg::ST_MODE_LO] <= mode_r;
					prdata[irpc_pkg::ST_HOLD]      <= !hold_ack_n;
					prdata[irpc_pkg::ST_IRQ_REQ]   <= irq_s;
				end
				irpc_pkg::OFS_VECTOR: begin
					prdata <= branch_addr;
				end
				default: begin
					pslverr <= 1'b1;
				end
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= irpc_pkg::CTRL_RST;
		end else if (wr_w && (paddr == irpc_pkg::OFS_CTRL)) begin
			ctrl_r <= pwdata[1:0];
		end
	end

	// ****************************************************************
	// Nonmaskable detection
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_prev_r <= 1'b1;
		end else begin
			nmi_prev_r <= nmi_s;
		end
	end

	// The clear at handler start wins: an edge in that cycle is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_latch_r <= 1'b0;
		end else if (nmi_take_w) begin
			nmi_latch_r <= 1'b0;
		end else if (nmi_fall_w) begin
			nmi_latch_r <= 1'b1;
		end
	end

	// Pending flag set by entry, cleared by software at handler end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_pend_r <= 1'b0;
		end else if (nmi_take_w) begin
			nmi_pend_r <= 1'b1;
		end else if (cmd_w && pwdata[irpc_pkg::CMD_NMI_DONE]) begin
			nmi_pend_r <= 1'b0;
		end
	end

	// Maskable in service until software posts acceptance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_busy_r <= 1'b0;
		end else if (irq_take_w) begin
			irq_busy_r <= 1'b1;
		end else if (cmd_w && pwdata[irpc_pkg::CMD_IRQ_ACK]) begin
			irq_busy_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Branch generation
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_r      <= 1'b1;
			branch_stb  <= 1'b0;
			branch_addr <= irpc_pkg::RESET_ADDR;
		end else begin
			boot_r     <= 1'b0;
			branch_stb <= boot_r || nmi_take_w || irq_take_w;
			if (boot_r) begin
				branch_addr <= irpc_pkg::RESET_ADDR;
			end else if (nmi_take_w) begin
				branch_addr <= irpc_pkg::NMI_ADDR;
			end else if (irq_take_w) begin
				branch_addr <= irq_vec_w;
			end
		end
	end

	// ****************************************************************
	// Power modes
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= irpc_pkg::MODE_RUN;
		end else begin
			case (mode_r)
				irpc_pkg::MODE_RUN: begin
					if (cmd_w && pwdata[irpc_pkg::CMD_STOP]) begin
						mode_r <= irpc_pkg::MODE_STOP;
					end else if (cmd_w && pwdata[irpc_pkg::CMD_SLEEP]) begin
						mode_r <= irpc_pkg::MODE_SLEEP;
					end
				end
				irpc_pkg::MODE_SLEEP: begin
					if (nmi_latch_r || irq_wake_w) begin
						mode_r <= irpc_pkg::MODE_RUN;
					end
				end
				irpc_pkg::MODE_STOP: begin
					if (nmi_latch_r) begin
						mode_r <= irpc_pkg::MODE_RUN;
					end
				end
				default: begin
					mode_r <= irpc_pkg::MODE_RUN;
				end
			endcase
		end
	end

	// Clock gating follows the mode; memories are not touched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_clk_en <= 1'b1;
			pll_run     <= 1'b1;
		end else begin
			core_clk_en <= (mode_r == irpc_pkg::MODE_RUN);
			pll_run     <= (mode_r != irpc_pkg::MODE_STOP);
		end
	end

	// ****************************************************************
	// Bus hold and status pins
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_ack_n <= 1'b1;
			st_oe      <= 1'b1;
			st_out     <= irpc_pkg::STAT_RUN;
		end else begin
			hold_ack_n <= !hold_grant_w;
			st_oe      <= !hold_grant_w;
			st_out     <= (mode_r == irpc_pkg::MODE_SLEEP) ? irpc_pkg::STAT_HALT_ACK
				: irpc_pkg::STAT_RUN;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stop_nmi;
		(mode_r == irpc_pkg::MODE_STOP) && nmi_latch_r;
	endsequence

	sequence s_wake_run;
		(mode_r == irpc_pkg::MODE_RUN) ##1 core_clk_en;
	endsequence

	property p_irq_level;
		irq_take_w |=> branch_stb && (branch_addr[7:4] == $past(level_w));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("level index wrong");

	property p_irq_area;
		irq_take_w && ctrl_r[irpc_pkg::CTRL_AREA_SEL]
			|=> (branch_addr[31:8] == irpc_pkg::IRQ_BASE_INT[31:8]);
	endproperty
	a_irq_area: assert property (p_irq_area) else $error("internal base wrong");

	property p_nmi_detect;
		nmi_fall_w && !nmi_take_w |=> nmi_latch_r;
	endproperty
	a_nmi_detect: assert property (p_nmi_detect) else $error("edge not latched");

	property p_nmi_hold;
		nmi_latch_r && !nmi_take_w |=> nmi_latch_r;
	endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("latch dropped");

	property p_nmi_vec;
		nmi_take_w |=> branch_stb && (branch_addr == irpc_pkg::NMI_ADDR) && nmi_pend_r;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("nmi entry wrong");

	property p_nmi_pend;
		nmi_pend_r && nmi_fall_w |=> nmi_latch_r;
	endproperty
	a_nmi_pend: assert property (p_nmi_pend) else $error("nested nmi taken");

	property p_nmi_lost;
		nmi_take_w |=> !nmi_latch_r;
	endproperty
	a_nmi_lost: assert property (p_nmi_lost) else $error("latch not cleared");

	property p_boot;
		boot_r |=> branch_stb && (branch_addr == irpc_pkg::RESET_ADDR) && !boot_r;
	endproperty
	a_boot: assert property (p_boot) else $error("reset fetch wrong");

	property p_stop_wake;
		s_stop_nmi |=> s_wake_run;
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("stop not left");

	property p_stop_stay;
		(mode_r == irpc_pkg::MODE_STOP) && !nmi_latch_r |=> !core_clk_en && !pll_run;
	endproperty
	a_stop_stay: assert property (p_stop_stay) else $error("stop clock on");

	property p_stop_hold;
		(mode_r == irpc_pkg::MODE_STOP) |=> hold_ack_n;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("hold granted in stop");

	property p_hold_float;
		!hold_ack_n |-> !st_oe;
	endproperty
	a_hold_float: assert property (p_hold_float) else $error("status driven in hold");

	property p_nmi_first;
		branch_stb && !$past(boot_r) && (branch_addr != irpc_pkg::NMI_ADDR) |-> !nmi_latch_r;
	endproperty
	a_nmi_first: assert property (p_nmi_first) else $error("irq beat nmi");

	property p_sleep_wake;
		(mode_r == irpc_pkg::MODE_SLEEP) && irq_wake_w |=> s_wake_run;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left");

endmodule : irpc_ctrl

// >>> irpc_req_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Request pin driver on the far side
// ****************************************************************
module irpc_req_model (
	// Clock
	input  wire logic pclk,
	// Request pins
	output logic       irq_req,
	output logic [3:0] irq_level_code_n,
	output logic       nmi_n,
	output logic       hold_req_n
);
	initial begin
		irq_req          = 1'b0;
		irq_level_code_n = 4'h5;
		nmi_n            = 1'b1;
		hold_req_n       = 1'b1;
	end

	// Level 15 is left to debug tools, so irq_on never presents it
	task automatic irq_on(input logic [3:0] lvl);
		irq_level_code_n <= 4'hF - ((lvl == 4'hF) ? 4'hE : lvl);
		irq_req          <= 1'b1;
	endtask : irq_on

	// Called once the branch is seen, before software posts acceptance; code lines then change
	task automatic irq_off();
		irq_req          <= 1'b0;
		irq_level_code_n <= ~irq_level_code_n;
	endtask : irq_off

	task automatic nmi_set(input logic v);
		nmi_n <= ~v;
	endtask : nmi_set

	task automatic hold(input logic v);
		hold_req_n <= ~v;
	endtask : hold
endmodule : irpc_req_model

// >>> tb.sv
`timescale 1ns/1ns
module tb;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, branch_addr, rd_d, x;
	logic        pready, pslverr, irq_req, nmi_n, hold_req_n, hold_ack_n;
	logic        st_oe, branch_stb, core_clk_en, pll_run, rd_e;
	logic [3:0]  irq_level_code_n, st_out, lvl;
	logic [31:0] exp_q[$];
	int          n_mismatch, n_checks, n_br, n_wt;
	// Settling allowance for the clock generator, value arbitrary
	localparam int PLL_SETTLE = 10;

	// ****************************************************************
	// Clock, design and far side
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	irpc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_req(irq_req),
		.irq_level_code_n(irq_level_code_n), .nmi_n(nmi_n), .hold_req_n(hold_req_n),
		.hold_ack_n(hold_ack_n), .st_out(st_out), .st_oe(st_oe),
		.branch_addr(branch_addr), .branch_stb(branch_stb),
		.core_clk_en(core_clk_en), .pll_run(pll_run));

	irpc_req_model req_u (.pclk(pclk), .irq_req(irq_req), .irq_level_code_n(irq_level_code_n),
		.nmi_n(nmi_n), .hold_req_n(hold_req_n));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Entered just after a rising edge; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd_d = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, n < 50}, 32'h1);
		// Idle edge so that a following setup never reassigns psel in this step
		@(posedge pclk);
	endtask : apb

	// Waits until the monitor has seen one more branch than already waited for;
	// counting targets keeps back-to-back strobes from being merged by a race
	task automatic wait_br();
		int n;
		n = 0;
		n_wt++;
		while (n_br < n_wt && n < 30) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, n < 30}, 32'h1);
	endtask : wait_br

	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd

	function automatic logic [31:0] vec(input logic [3:0] l, input logic area);
		return (area ? irpc_pkg::IRQ_BASE_INT : irpc_pkg::IRQ_BASE_EXT) | ({28'h0, l} << 4);
	endfunction : vec

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// Any strobe with no note waiting is itself a mismatch
	always @(posedge pclk) begin
		if (presetn === 1'b1 && branch_stb === 1'b1) begin
			n_br++;
			if (exp_q.size() == 0)
				chk(branch_addr, 32'h0);
			else
				chk(branch_addr, exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		$display("unexpected at %0t: run hung", $time);
		report_and_stop();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; x = 32'd5181; n_br = 0;
		n_wt = 1;
		exp_q.push_back(irpc_pkg::RESET_ADDR);
		cyc(6);
		presetn <= 1'b1;
		cyc(1);
		apb(1'b0, irpc_pkg::OFS_CTRL, 32'h0);
		chk(rd_d, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rd_e}, 32'h1);
		chk({31'h0, exp_q.size() == 0}, 32'h1);
		$display("test reset done");

		for (int i = 0; i < 8; i++) begin
			rnd();
			lvl = (i == 0) ? 4'h0 : (i == 1) ? 4'hE : 4'(x % 15);
			apb(1'b1, irpc_pkg::OFS_CTRL, {30'h0, 1'b1, x[4]});
			exp_q.push_back(vec(lvl, x[4]));
			req_u.irq_on(lvl);
			wait_br();
			req_u.irq_off();
			cyc(4);
			apb(1'b1, irpc_pkg::OFS_CMD, 32'h4);
		end
		$display("test levels done");

		exp_q.push_back(irpc_pkg::NMI_ADDR);
		req_u.nmi_set(1'b1);
		cyc(2);
		req_u.nmi_set(1'b0);
		wait_br();
		apb(1'b0, irpc_pkg::OFS_STATUS, 32'h0);
		chk({31'h0, rd_d[1]}, 32'h1);
		req_u.nmi_set(1'b1);
		cyc(2);
		req_u.nmi_set(1'b0);
		cyc(8);
		apb(1'b0, irpc_pkg::OFS_STATUS, 32'h0);
		chk({31'h0, rd_d[0]}, 32'h1);
		exp_q.push_back(irpc_pkg::NMI_ADDR);
		apb(1'b1, irpc_pkg::OFS_CMD, 32'h8);
		wait_br();
		apb(1'b1, irpc_pkg::OFS_CMD, 32'h8);
		$display("test nmi done");

		exp_q.push_back(irpc_pkg::NMI_ADDR);
		exp_q.push_back(vec(4'h7, x[4]));
		req_u.nmi_set(1'b1);
		req_u.irq_on(4'h7);
		cyc(2);
		req_u.nmi_set(1'b0);
		wait_br();
		wait_br();
		req_u.irq_off();
		cyc(4);
		apb(1'b1, irpc_pkg::OFS_CMD, 32'hC);
		$display("test priority done");

		apb(1'b1, irpc_pkg::OFS_CTRL, {30'h0, 1'b0, x[4]});
		req_u.irq_on(4'h2);
		cyc(4);
		req_u.irq_on(4'h9);
		cyc(4);
		exp_q.push_back(vec(4'h9, x[4]));
		apb(1'b1, irpc_pkg::OFS_CTRL, {30'h0, 1'b1, x[4]});
		wait_br();
		req_u.irq_off();
		cyc(4);
		apb(1'b1, irpc_pkg::OFS_CMD, 32'h4);
		$display("test raise done");

		apb(1'b1, irpc_pkg::OFS_CMD, 32'h1);
		cyc(3);
		chk({30'h0, core_clk_en, pll_run}, 32'h1);
		chk({28'h0, st_out}, {28'h0, irpc_pkg::STAT_HALT_ACK});
		req_u.hold(1'b1);
		cyc(4);
		chk({30'h0, st_oe, hold_ack_n}, 32'h0);
		req_u.hold(1'b0);
		cyc(4);
		chk({27'h0, st_oe, st_out}, {27'h0, 1'b1, irpc_pkg::STAT_HALT_ACK});
		exp_q.push_back(vec(4'h3, x[4]));
		req_u.irq_on(4'h3);
		wait_br();
		cyc(3);
		chk({31'h0, core_clk_en}, 32'h1);
		req_u.irq_off();
		cyc(4);
		apb(1'b1, irpc_pkg::OFS_CMD, 32'h4);
		$display("test sleep done");

		apb(1'b1, irpc_pkg::OFS_CMD, 32'h2);
		cyc(3);
		chk({30'h0, core_clk_en, pll_run}, 32'h0);
		req_u.hold(1'b1);
		req_u.irq_on(4'h5);
		cyc(8);
		chk({30'h0, core_clk_en, hold_ack_n}, 32'h1);
		req_u.hold(1'b0);
		cyc(4);
		exp_q.push_back(irpc_pkg::NMI_ADDR);
		exp_q.push_back(vec(4'h5, x[4]));
		req_u.nmi_set(1'b1);
		cyc(2);
		req_u.nmi_set(1'b0);
		wait_br();
		wait_br();
		cyc(3);
		chk({30'h0, core_clk_en, pll_run}, 32'h3);
		req_u.irq_off();
		cyc(4);
		apb(1'b1, irpc_pkg::OFS_CMD, 32'hC);
		cyc(4);
		chk({31'h0, exp_q.size() == 0}, 32'h1);
		$display("test stop done");

		apb(1'b1, irpc_pkg::OFS_CMD, 32'h2);
		presetn <= 1'b0;
		cyc(PLL_SETTLE + 20);
		chk({30'h0, core_clk_en, pll_run}, 32'h3);
		exp_q.push_back(irpc_pkg::RESET_ADDR);
		presetn <= 1'b1;
		wait_br();
		apb(1'b0, irpc_pkg::OFS_CTRL, 32'h0);
		chk(rd_d, 32'h0);
		chk({31'h0, exp_q.size() == 0}, 32'h1);
		$display("test stop reset done");
		report_and_stop();
	end
endmodule : tb
